// ### hw/tcx_pkg.sv
package tcx_pkg;

    // input event actions
    typedef enum logic [2:0] {
        TCX_ACT_OFF               = 3'h0,
        TCX_ACT_RETRIGGER         = 3'h1,
        TCX_ACT_COUNT_EV          = 3'h2,
        TCX_ACT_START             = 3'h3,
        TCX_ACT_STEP              = 3'h4,
        TCX_ACT_PERIOD_THEN_WIDTH = 3'h5,
        TCX_ACT_WIDTH_THEN_PERIOD = 3'h6
    } tcx_event_action_sel_t;

    // software commands in control_b
    typedef enum logic [1:0] {
        TCX_CMD_NONE      = 2'h0,
        TCX_CMD_RETRIGGER = 2'h1,
        TCX_CMD_STOP      = 2'h2
    } tcx_cmd_t;

    // write synchronizer states, gray along idle-wait-apply
    typedef enum logic [1:0] {
        TCX_SYNC_IDLE  = 2'h0,
        TCX_SYNC_WAIT  = 2'h1,
        TCX_SYNC_APPLY = 2'h3
    } tcx_sync_state_t;

endpackage

// ### hw/tcx_regs.svh
`ifndef TCX_REGS_SVH
`define TCX_REGS_SVH

// register indices, byte address is four times the index
`define TCX_IDX_CTRL_MAIN     5'h00
`define TCX_IDX_READ_REQ      5'h02
`define TCX_IDX_CTRLB_CLR     5'h04
`define TCX_IDX_CTRLB_SET     5'h05
`define TCX_IDX_CAPTURE_CTRL  5'h06
`define TCX_IDX_DEBUG_CTRL    5'h08
`define TCX_IDX_EVENT_CTRL    5'h0a
`define TCX_IDX_IRQ_EN_CLR    5'h0c
`define TCX_IDX_IRQ_EN_SET    5'h0d
`define TCX_IDX_IRQ_FLAGS     5'h0e
`define TCX_IDX_STATUS        5'h0f
`define TCX_IDX_COUNT         5'h10
`define TCX_IDX_PERIOD        5'h14
`define TCX_IDX_CC0           5'h18
`define TCX_IDX_CC1           5'h19

// control_main fields
`define TCX_CM_SOFT_RESET_BIT          0
`define TCX_CM_ENABLE         1
`define TCX_CM_RUN_IN_STANDBY       11
// control_b fields
`define TCX_CB_DIR            0
`define TCX_CB_ONESHOT        2
`define TCX_CB_CMD_LSB        6
`define TCX_CB_STORE_MASK     8'h05
// capture_control fields
`define TCX_CC_CPTEN_LSB      4
// event_control fields
`define TCX_EV_ACT_LSB        0
`define TCX_EV_INVERT         4
`define TCX_EV_INPUT_EN       5
`define TCX_EV_OVF_OUT        8
`define TCX_EV_MC_OUT_LSB     12
// debug_control field
`define TCX_DBG_RUN           0
// read_request fields kept
`define TCX_RR_STORE_MASK     16'h401f
// irq flag positions
`define TCX_IRQ_OVF           0
`define TCX_IRQ_ERR           1
`define TCX_IRQ_SYNCRDY       3
`define TCX_IRQ_MC_LSB        4
// counter_status positions
`define TCX_ST_STOP           3
`define TCX_ST_SYNC_PENDING   7

// reset values
`define TCX_PERIOD_RESET      8'hff
// clk cycles a synchronized write waits before its apply cycle
`define TCX_SYNC_CYCLES       3

`endif

// ### hw/tcx_sync.sv
`timescale 1ns/1ps
`include "tcx_regs.svh"
module tcx_sync #(
    parameter int SYNC_CYCLES = `TCX_SYNC_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // write hand-over
    tcx_sync_if.sync port
);
    tcx_pkg::tcx_sync_state_t state;      // current state
    logic [3:0]               wait_cnt;   // cycles left in flight
    logic [4:0]               held_idx;   // captured index
    logic [15:0]              held_data;  // captured data

    // busy from acceptance until the applying edge
    assign port.busy       = (state != tcx_pkg::TCX_SYNC_IDLE);
    assign port.apply      = (state == tcx_pkg::TCX_SYNC_APPLY);
    assign port.apply_idx  = held_idx;
    assign port.apply_data = held_data;

    // hold the write, count the crossing delay, then apply
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state     <= tcx_pkg::TCX_SYNC_IDLE;
            wait_cnt  <= 4'h0;
            held_idx  <= 5'h00;
            held_data <= 16'h0000;
        end else begin
            case (state)
                tcx_pkg::TCX_SYNC_IDLE: begin
                    // take a new write
                    if (port.req) begin
                        held_idx  <= port.idx;
                        held_data <= port.data;
                        wait_cnt  <= 4'(SYNC_CYCLES - 1);
                        state     <= tcx_pkg::TCX_SYNC_WAIT;
                    end
                end
                tcx_pkg::TCX_SYNC_WAIT: begin
                    // crossing delay
                    if (wait_cnt == 4'h0) begin
                        state <= tcx_pkg::TCX_SYNC_APPLY;
                    end else begin
                        wait_cnt <= wait_cnt - 4'h1;
                    end
                end
                tcx_pkg::TCX_SYNC_APPLY: begin
                    state <= tcx_pkg::TCX_SYNC_IDLE;
                end
                default: begin
                    state <= tcx_pkg::TCX_SYNC_IDLE;
                end
            endcase
        end
    end
endmodule

// ### hw/tcx_sync_if.sv
`timescale 1ns/1ps
interface tcx_sync_if;
    logic        req;        // write accepted on the bus
    logic [4:0]  idx;        // register index of the write
    logic [15:0] data;       // write data
    logic        busy;       // write still in flight
    logic        apply;      // value takes effect this edge
    logic [4:0]  apply_idx;  // index being applied
    logic [15:0] apply_data; // data being applied

    modport ctrl (output req, idx, data, input busy, apply, apply_idx, apply_data);
    modport sync (input req, idx, data, output busy, apply, apply_idx, apply_data);
endinterface

// ### hw/tcx_timer_counter.sv
// Summary of operation
// - emits overflow event and per-channel match events
// - match event only while its enable bit set
// - event_action_sel picks exactly one input action
// - input events ignored while event_input_en clear
// - standby halts counter unless run_in_standby set
// - running in sleep still raises irq, events
// - soft reset, enable writes cross before effect
// - control, count, period, compare writes synchronized
// - those registers read back counter-side values
// - 8-bit count, period, compares at own offsets
// - control registers keep the same offsets
// - capture order picks period and width channels
// - invert moves restart to falling edge
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "tcx_regs.svh"
module tcx_timer_counter #(
    parameter int CHANNELS    = 2,
    parameter int SYNC_CYCLES = `TCX_SYNC_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // apb slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // event input from routing, asynchronous
    input  wire logic        event_in,
    // power and debug state
    input  wire logic        standby,
    input  wire logic        debug_halt,
    // event outputs and interrupt
    output logic             ovf_event,
    output logic [1:0]       mc_event,
    output logic             irq
);
    // software registers
    logic [15:0]         ctrl_main;     // control_main
    logic [15:0]         read_req;      // read_request
    logic [7:0]          ctrl_b;        // dir and one-shot
    logic [7:0]          capture_ctrl;  // capture_control
    logic [7:0]          debug_ctrl;    // debug_control
    logic [15:0]         event_ctrl;    // event_control
    logic [7:0]          irq_en;        // interrupt enables
    logic [7:0]          irq_flags;     // sticky flags
    // counter state
    logic [7:0]          count;         // count_value
    logic [7:0]          period;        // period_value
    logic [CHANNELS-1:0][7:0] cc;       // compare_capture values
    logic                running;       // low while stopped
    // event input synchronizer and edge history
    logic                ev_meta;       // first stage
    logic                ev_sync;       // second stage
    logic                ev_prev;       // previous oriented level

    tcx_sync_if sif();

    tcx_sync #(
        .SYNC_CYCLES (SYNC_CYCLES)
    ) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .port (sif)
    );

    // registers whose writes cross into the counter side
    function automatic logic is_synced(input logic [4:0] i);
        return (i == `TCX_IDX_CTRL_MAIN)    || (i == `TCX_IDX_CTRLB_CLR) ||
               (i == `TCX_IDX_CTRLB_SET)    || (i == `TCX_IDX_CAPTURE_CTRL) ||
               (i == `TCX_IDX_COUNT)        || (i == `TCX_IDX_PERIOD) ||
               (i == `TCX_IDX_CC0)          || (i == `TCX_IDX_CC1);
    endfunction

    // every decoded index
    function automatic logic is_mapped(input logic [4:0] i);
        return is_synced(i) || (i == `TCX_IDX_READ_REQ) ||
               (i == `TCX_IDX_DEBUG_CTRL) || (i == `TCX_IDX_EVENT_CTRL) ||
               (i == `TCX_IDX_IRQ_EN_CLR) || (i == `TCX_IDX_IRQ_EN_SET) ||
               (i == `TCX_IDX_IRQ_FLAGS)  || (i == `TCX_IDX_STATUS);
    endfunction

    // bus decode
    wire [4:0]  idx        = paddr[6:2];
    wire        addr_ok    = (paddr[1:0] == 2'h0) && !paddr[7] && is_mapped(idx);
    wire        sync_stall = pwrite && addr_ok && is_synced(idx) && sif.busy;
    wire        acc_go     = psel && penable && !pready && !sync_stall;
    wire        wr_fire    = psel && penable && pready && pwrite && !pslverr;
    wire        wr_direct  = wr_fire && !is_synced(idx);
    wire [15:0] wdata      = pwdata[15:0];

    // hand a synchronized write to the crossing stage
    assign sif.req  = wr_fire && is_synced(idx);
    assign sif.idx  = idx;
    assign sif.data = wdata;

    // applied writes, one pulse each
    wire ap        = sif.apply;
    wire ap_main   = ap && (sif.apply_idx == `TCX_IDX_CTRL_MAIN);
    wire ap_b_clr  = ap && (sif.apply_idx == `TCX_IDX_CTRLB_CLR);
    wire ap_b_set  = ap && (sif.apply_idx == `TCX_IDX_CTRLB_SET);
    wire ap_cap    = ap && (sif.apply_idx == `TCX_IDX_CAPTURE_CTRL);
    wire ap_count  = ap && (sif.apply_idx == `TCX_IDX_COUNT);
    wire ap_period = ap && (sif.apply_idx == `TCX_IDX_PERIOD);
    wire [7:0] ap_byte = sif.apply_data[7:0];

    // soft reset acts only once crossed
    wire soft_rst  = ap_main && sif.apply_data[`TCX_CM_SOFT_RESET_BIT];
    wire rst_all   = !nrst || soft_rst;

    // control fields
    wire        enabled      = ctrl_main[`TCX_CM_ENABLE];
    wire        en_rise      = ap_main && !enabled && sif.apply_data[`TCX_CM_ENABLE];
    wire        run_stdby    = ctrl_main[`TCX_CM_RUN_IN_STANDBY];
    wire        count_down   = ctrl_b[`TCX_CB_DIR];
    wire        one_shot     = ctrl_b[`TCX_CB_ONESHOT];
    wire [1:0]  cpten        = capture_ctrl[`TCX_CC_CPTEN_LSB +: 2];
    wire        input_en     = event_ctrl[`TCX_EV_INPUT_EN];
    wire        invert       = event_ctrl[`TCX_EV_INVERT];
    wire        ovf_out_en   = event_ctrl[`TCX_EV_OVF_OUT];
    wire [1:0]  mc_out_en    = event_ctrl[`TCX_EV_MC_OUT_LSB +: 2];
    wire tcx_pkg::tcx_event_action_sel_t act = tcx_pkg::tcx_event_action_sel_t'(event_ctrl[`TCX_EV_ACT_LSB +: 3]);
    wire tcx_pkg::tcx_cmd_t   cmd = ap_b_set ?
        tcx_pkg::tcx_cmd_t'(ap_byte[`TCX_CB_CMD_LSB +: 2]) : tcx_pkg::TCX_CMD_NONE;

    // halt in standby unless allowed to run, or under debug
    wire halted = (standby && !run_stdby) ||
                  (debug_halt && !debug_ctrl[`TCX_DBG_RUN]);
    wire live   = enabled && !halted;

    // oriented event level and its edges, gated by input enable
    wire ev_lvl  = ev_sync ^ invert;
    wire ev_rise = input_en && live && ev_lvl && !ev_prev;
    wire ev_fall = input_en && live && !ev_lvl && ev_prev;

    // one decoded action at a time
    wire act_retrig = (act == tcx_pkg::TCX_ACT_RETRIGGER);
    wire act_start  = (act == tcx_pkg::TCX_ACT_START);
    wire act_evcnt  = (act == tcx_pkg::TCX_ACT_COUNT_EV) ||
                      (act == tcx_pkg::TCX_ACT_STEP);
    wire act_ppw    = (act == tcx_pkg::TCX_ACT_PERIOD_THEN_WIDTH);
    wire act_pwp    = (act == tcx_pkg::TCX_ACT_WIDTH_THEN_PERIOD);
    wire cap_mode   = act_ppw || act_pwp;
    wire per_ch     = act_pwp;

    // counting step and wrap
    wire       tick     = live && running && (act_evcnt ? ev_rise : 1'b1);
    wire       at_top   = count_down ? (count == 8'h00) : (count == period);
    wire       wrap     = tick && at_top;
    wire [7:0] step_val = at_top ? (count_down ? period : 8'h00) :
                          (count_down ? count - 8'h01 : count + 8'h01);

    // restart sources: events, command, capture restart edge
    wire start_ev  = act_start && ev_rise && !running;
    wire restart   = live && ((act_retrig && ev_rise) || start_ev ||
                     (cmd == tcx_pkg::TCX_CMD_RETRIGGER) || (cap_mode && ev_rise));
    wire stop_now  = (cmd == tcx_pkg::TCX_CMD_STOP) || (wrap && one_shot) ||
                     (en_rise && act_start);
    wire [7:0] next_count = ap_count ? ap_byte :
                            restart ? (count_down ? period : 8'h00) :
                            tick ? step_val : count;
    wire next_running = restart ? 1'b1 : stop_now ? 1'b0 : running;

    // per channel match and capture
    logic [CHANNELS-1:0] mc_hit;   // match or stored capture
    logic [CHANNELS-1:0] cap_err;  // capture while flag still set

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            wire is_per   = (1'(ch) == per_ch);
            wire cap_hit  = cap_mode && cpten[ch] && (is_per ? ev_rise : ev_fall);
            wire flag_set = irq_flags[`TCX_IRQ_MC_LSB + ch];
            wire cap_ok   = cap_hit && !flag_set;
            wire match    = tick && !cpten[ch] && (count == cc[ch]);
            wire wr_cc    = ap && (sif.apply_idx == ((ch == 0) ? `TCX_IDX_CC0 : `TCX_IDX_CC1));
            assign mc_hit[ch]  = match || cap_ok;
            assign cap_err[ch] = cap_hit && flag_set;

            // compare value, capture wins over a crossed write
            always_ff @(posedge clk) begin
                if (rst_all) begin
                    cc[ch] <= 8'h00;
                end else if (cap_ok) begin
                    cc[ch] <= count;
                end else if (wr_cc) begin
                    cc[ch] <= ap_byte;
                end
            end
        end
    endgenerate

    // interrupt sources in flag layout
    wire [7:0] irq_set = {2'b00, mc_hit, ap, 1'b0, |cap_err, wrap};
    wire [7:0] irq_w1c = (wr_direct && idx == `TCX_IDX_IRQ_FLAGS) ? wdata[7:0] : 8'h00;
    wire [7:0] next_flags = (irq_flags & ~irq_w1c) | irq_set;

    // status as seen by software
    wire [7:0] status_val = ({7'h00, sif.busy} << `TCX_ST_SYNC_PENDING) |
                            ({7'h00, !running} << `TCX_ST_STOP);

    // read data, counter-side copies for the synchronized set
    wire [31:0] rd_value =
        (idx == `TCX_IDX_CTRL_MAIN)    ? {16'h0000, ctrl_main} :
        (idx == `TCX_IDX_READ_REQ)     ? {16'h0000, read_req} :
        (idx == `TCX_IDX_CTRLB_CLR)    ? {24'h000000, ctrl_b} :
        (idx == `TCX_IDX_CTRLB_SET)    ? {24'h000000, ctrl_b} :
        (idx == `TCX_IDX_CAPTURE_CTRL) ? {24'h000000, capture_ctrl} :
        (idx == `TCX_IDX_DEBUG_CTRL)   ? {24'h000000, debug_ctrl} :
        (idx == `TCX_IDX_EVENT_CTRL)   ? {16'h0000, event_ctrl} :
        (idx == `TCX_IDX_IRQ_EN_CLR)   ? {24'h000000, irq_en} :
        (idx == `TCX_IDX_IRQ_EN_SET)   ? {24'h000000, irq_en} :
        (idx == `TCX_IDX_IRQ_FLAGS)    ? {24'h000000, irq_flags} :
        (idx == `TCX_IDX_STATUS)       ? {24'h000000, status_val} :
        (idx == `TCX_IDX_COUNT)        ? {24'h000000, count} :
        (idx == `TCX_IDX_PERIOD)       ? {24'h000000, period} :
        (idx == `TCX_IDX_CC0)          ? {24'h000000, cc[0]} :
        (idx == `TCX_IDX_CC1)          ? {24'h000000, cc[1]} : 32'h00000000;

    // apb answer: one wait state, stretched for a synchronized write while a crossing is busy
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc_go;
            pslverr <= acc_go && !addr_ok;
            if (acc_go) begin
                prdata <= (pwrite || !addr_ok) ? 32'h00000000 : rd_value;
            end
        end
    end

    // event pin, two stages before any logic
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ev_meta <= 1'b0;
            ev_sync <= 1'b0;
            ev_prev <= 1'b0;
        end else begin
            ev_meta <= event_in;
            ev_sync <= ev_meta;
            ev_prev <= ev_lvl;
        end
    end

    // crossed control registers
    always_ff @(posedge clk) begin
        if (rst_all) begin
            ctrl_main    <= 16'h0000;
            ctrl_b       <= 8'h00;
            capture_ctrl <= 8'h00;
        end else begin
            if (ap_main) begin
                ctrl_main <= sif.apply_data & ~16'h0001;
            end
            if (ap_b_set) begin
                ctrl_b <= ctrl_b | (ap_byte & `TCX_CB_STORE_MASK);
            end else if (ap_b_clr) begin
                ctrl_b <= ctrl_b & ~(ap_byte & `TCX_CB_STORE_MASK);
            end
            if (ap_cap) begin
                capture_ctrl <= ap_byte;
            end
        end
    end

    // directly written registers
    always_ff @(posedge clk) begin
        if (rst_all) begin
            read_req   <= 16'h0000;
            debug_ctrl <= 8'h00;
            event_ctrl <= 16'h0000;
            irq_en     <= 8'h00;
        end else if (wr_direct) begin
            case (idx)
                `TCX_IDX_READ_REQ:   read_req   <= wdata & `TCX_RR_STORE_MASK;
                `TCX_IDX_DEBUG_CTRL: debug_ctrl <= wdata[7:0];
                `TCX_IDX_EVENT_CTRL: event_ctrl <= wdata;
                `TCX_IDX_IRQ_EN_SET: irq_en     <= irq_en | wdata[7:0];
                `TCX_IDX_IRQ_EN_CLR: irq_en     <= irq_en & ~wdata[7:0];
                default:             irq_en     <= irq_en;
            endcase
        end
    end

    // counting core
    always_ff @(posedge clk) begin
        if (rst_all) begin
            count   <= 8'h00;
            period  <= `TCX_PERIOD_RESET;
            running <= 1'b1;
        end else begin
            count   <= next_count;
            running <= next_running;
            if (ap_period) begin
                period <= ap_byte;
            end
        end
    end

    // flags, set wins over a same-cycle clear
    always_ff @(posedge clk) begin
        if (rst_all) begin
            irq_flags <= 8'h00;
        end else begin
            irq_flags <= next_flags;
        end
    end

    // registered outputs: events and interrupt line
    always_ff @(posedge clk) begin
        if (rst_all) begin
            ovf_event <= 1'b0;
            mc_event  <= 2'b00;
            irq       <= 1'b0;
        end else begin
            ovf_event <= wrap && ovf_out_en;
            mc_event  <= mc_hit & mc_out_en;
            irq       <= |(next_flags & irq_en);
        end
    end

endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr;  // clock, reset, apb
    logic [7:0]  paddr;                                               // byte address
    logic [31:0] pwdata, prdata, rd_data;                             // bus data
    logic        rd_err, event_in, standby, ovf_event, irq;           // answers, events
    logic        debug_halt;                                          // debugger halt level
    logic [1:0]  mc_event;                                            // match pulses
    int          err_count, n_checks, n_ovf, n_mc0;                   // tallies
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    tcx_timer_counter uut (.clk(clk), .nrst(nrst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_in(event_in),
        .standby(standby), .debug_halt(debug_halt), .ovf_event(ovf_event),
        .mc_event(mc_event), .irq(irq));
    tcx_event_src src (.clk(clk), .event_in(event_in));
    // tally output event pulses
    always @(posedge clk) begin
        if (ovf_event === 1'b1) n_ovf++;
        if (mc_event[0] === 1'b1) n_mc0++;
    end
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only the watchdog ends a wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task t_reset;
        apb(0, 8'h50, 0); chk(rd_data, 32'hff);
        apb(0, 8'h40, 0); chk(rd_data, 32'h0);
        apb(0, 8'h64, 0); chk(rd_data, 32'h0);
        apb(0, 8'h00, 0); chk(rd_data, 32'h0);
        apb(0, 8'h1c, 0); chk(rd_err, 1'b1);
        $display("test reset done");
    endtask
    task t_sync;
        apb(1, 8'h50, 32'h05);
        apb(1, 8'h50, 32'h05);
        apb(0, 8'h3c, 0); chk(rd_data & 32'h80, 32'h80);
        repeat (8) @(posedge clk);
        apb(0, 8'h50, 0); chk(rd_data, 32'h05);
        apb(0, 8'h3c, 0); chk(rd_data & 32'h80, 32'h0);
        apb(0, 8'h38, 0); chk(rd_data & 32'h08, 32'h08);
        apb(1, 8'h38, 32'h08);
        apb(0, 8'h38, 0); chk(rd_data & 32'h08, 32'h0);
        $display("test sync done");
    endtask
    task t_evin;
        apb(1, 8'h28, 32'h02);
        apb(1, 8'h00, 32'h02);
        src.fire(2);
        apb(0, 8'h40, 0); chk(rd_data, 32'h0);
        // count on event, then step upwards
        for (int i = 0; i < 2; i++) begin
            apb(1, 8'h28, i ? 32'h24 : 32'h22);
            apb(1, 8'h40, 32'h0);
            repeat (5) @(posedge clk); // let the count write land first
            src.fire(3);
            apb(0, 8'h40, 0); chk(rd_data, 32'h03);
        end
        $display("test event input done");
    endtask
    task t_events;
        apb(1, 8'h60, 32'h04);
        apb(1, 8'h34, 32'h01);
        apb(1, 8'h28, 32'h1122);
        n_ovf = 0;
        n_mc0 = 0;
        src.fire(3);
        chk(n_mc0, 1);
        chk(n_ovf, 1);
        chk(irq, 1'b1);
        apb(1, 8'h38, 32'h01);
        repeat (3) @(posedge clk);
        chk(irq, 1'b0);
        apb(1, 8'h28, 32'h0122);
        src.fire(5); // one match at count 4 with its output off
        chk(n_mc0, 1);
        $display("test output events done");
    endtask
    task t_standby;
        @(posedge clk);
        standby <= 1'b1;
        src.fire(1);
        apb(0, 8'h40, 0); chk(rd_data, 32'h05);
        apb(1, 8'h00, 32'h0802);
        repeat (5) @(posedge clk); // run_in_standby in effect first
        n_ovf = 0;
        src.fire(1); // count at period wraps to zero
        apb(0, 8'h40, 0); chk(rd_data, 32'h00);
        chk(n_ovf, 1);
        chk(irq, 1'b1);
        standby <= 1'b0;
        debug_halt <= 1'b1;
        src.fire(1);
        apb(0, 8'h40, 0); chk(rd_data, 32'h00);
        debug_halt <= 1'b0;
        $display("test standby done");
    endtask
    // width_then_period: width lands in channel 0
    task t_capture;
        apb(1, 8'h18, 32'h30);
        apb(1, 8'h28, 32'h26);
        apb(1, 8'h38, 32'hff);
        src.fire(1);
        apb(0, 8'h60, 0); chk(rd_data, 32'h02);
        $display("test capture done");
    endtask
    // cut a hang well past the expected run
    initial begin
        #(25 * 20000);
        err_count++;
        wrap_up;
    end
    initial begin
        nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0;
        pwdata = 32'h0; standby = 1'b0; err_count = 0; n_checks = 0; n_ovf = 0; n_mc0 = 0;
        debug_halt = 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_reset;
        t_sync;
        t_evin;
        t_events;
        t_standby;
        t_capture;
        wrap_up;
    end
endmodule
bind tcx_timer_counter tcx_properties #(.CHANNELS(CHANNELS), .SYNC_CYCLES(SYNC_CYCLES))
    u_props (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ovf_event(ovf_event), .mc_event(mc_event), .irq(irq));

// ### tb/tcx_event_src.sv
`timescale 1ns/1ps
module tcx_event_src (
    // clock
    input wire logic clk,
    // event level towards the counter
    output logic     event_in
);
    initial event_in = 1'b0; // idle low
    // raw level pair per event, three clocks per level for the input stage
    task automatic fire(input int n);
        repeat (n) begin
            @(posedge clk);
            event_in <= 1'b1;
            repeat (3) @(posedge clk);
            event_in <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask
endmodule

// ### tb/tcx_properties.sv
`timescale 1ns/1ps
module tcx_properties #(
    parameter int CHANNELS    = 2,
    parameter int SYNC_CYCLES = 3
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        nrst,
    // apb slave side
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // events and interrupt
    input wire logic        ovf_event,
    input wire logic [1:0]  mc_event,
    input wire logic        irq
);
    localparam int ANS_MAX = SYNC_CYCLES + 9; // longest wait for an answer
    wire acc = psel && penable && pready;       // transfer taken
    // write to a register that crosses into the counter domain
    wire sync_wr = acc && pwrite && (paddr inside {8'h00, 8'h10, 8'h14, 8'h18,
                                                   8'h40, 8'h50, 8'h60, 8'h64});
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // setup then first access cycle
    sequence setup_s; psel && !penable; endsequence
    sequence first_acc_s; psel && penable; endsequence
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_one_wait: assert property (setup_s ##1 first_acc_s |-> !pready)
        else $error("answer without wait state");
    a_answer_bound: assert property (setup_s ##1 first_acc_s |-> ##[1:ANS_MAX] pready)
        else $error("no answer in time");
    a_err_answer: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer malformed");
    a_write_zero: assert property (acc && pwrite |-> prdata == 32'h0)
        else $error("read data on write answer");
    a_sync_hold: assert property (sync_wr |=> !sync_wr [*3])
        else $error("synced write accepted while pending");
    a_ovf_pulse: assert property (ovf_event |=> !ovf_event)
        else $error("overflow event longer than a cycle");
    a_mc_pulse: assert property (mc_event != 2'h0 |=> mc_event == 2'h0)
        else $error("match event longer than a cycle");
    a_reset_quiet: assert property (disable iff (1'b0)
        !nrst |=> !pready && !pslverr && !irq && !ovf_event && mc_event == 2'h0)
        else $error("outputs active in reset");
endmodule
